//--- design/link_pkg.sv
// constants for the interchip link frame port and its shared mode pins
// assumes a 250 MHz system clock and a byte-wide register port
// Behaviour
// - NT: timing pin high fixed, low adaptive
// - TE always uses adaptive timing recovery
// - adaptive tracks incoming baud, fixed tracks own
// - TE class is pin OR priority bit
// - class value 0 Class 1, 1 Class 2
// - NT star mode echoes echo pin as E
// - NT resets slave, master when bit set
// - TE is link master when loop active or master bit set
// - one-bit-clock sync pulse every 125 us
// - capture 20 bits on falls after sync
// - launch 20 bits on rises after sync
// - TE sync starts on leading edge, one period
// - TE sync phase-locks to received NT frame
// - TE without NT timing: free-run or low
// - NT slave accepts five clock rates, 8 kHz
// - NT master offers three rates, two bits
// - TE master offers two rates, one bit
// - transmit pin driven only 20 cycles, else off
// - TE outputs nothing until active loop or free-run
package link_pkg;
  // register indexes on the byte port
  localparam logic [7:0] ADDR_NIBBLE_TWO  = 8'h02;
  localparam logic [7:0] ADDR_BYTE_SEVEN  = 8'h07;
  localparam logic [7:0] ADDR_BYTE_THIRTN = 8'h0D;
  localparam logic [7:0] ADDR_STATUS      = 8'h10;
  // field positions
  localparam int PRIORITY_CLASS_POS = 0;
  localparam int CLK_RATE_A_POS     = 2;
  localparam int MASTER_FREERUN_POS = 3;
  localparam int CLK_RATE_B_POS     = 5;
  localparam int STAR_MODE_POS      = 7;
  // status bits
  localparam int ST_TE_POS       = 0;
  localparam int ST_LOOP_POS     = 1;
  localparam int ST_FIXED_POS    = 2;
  localparam int ST_CLASS2_POS   = 3;
  localparam int ST_MASTER_POS   = 4;
  localparam int ST_XFER_POS     = 5;
  // reset values
  localparam logic [3:0] NIBBLE_TWO_RST = 4'h0;
  localparam logic [7:0] BYTE_SEVEN_RST = 8'h00;
  localparam logic [7:0] BYTE_THIRTN_RST = 8'h00;
  // frame layout
  localparam int FRAME_BITS = 20;
  localparam logic [4:0] FRAME_BITS_W = 5'h14;
  localparam logic [19:0] IDLE_ONES = 20'hFFFFF;
  // master bit clock rates, selected from the two rate bits
  localparam logic [1:0] RATE_2048 = 2'h0;
  localparam logic [1:0] RATE_2560 = 2'h1;
  localparam logic [1:0] RATE_1536 = 2'h2;
  localparam real SYS_CLK_MHZ = 250.0;
  localparam real FRAME_US    = 125.0;
  localparam int  ACC_BITS    = 24;
  // phase increment per system clock: two toggles per bit clock period
  localparam logic [23:0] INC_2048 = 24'(longint'(2.0 * 2.048 * 16777216.0 / SYS_CLK_MHZ + 0.5));
  localparam logic [23:0] INC_2560 = 24'(longint'(2.0 * 2.56 * 16777216.0 / SYS_CLK_MHZ + 0.5));
  localparam logic [23:0] INC_1536 = 24'(longint'(2.0 * 1.536 * 16777216.0 / SYS_CLK_MHZ + 0.5));
  // bit clock periods per 125 us frame
  localparam logic [8:0] BITS_2048 = 9'(int'(FRAME_US * 2.048));
  localparam logic [8:0] BITS_2560 = 9'(int'(FRAME_US * 2.56));
  localparam logic [8:0] BITS_1536 = 9'(int'(FRAME_US * 1.536));
  // frame engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_XFER = 2'h2
  } frame_state_e;
endpackage

//--- design/link_timing_if.sv
// carrier between the frame port and its master timing generator
// assumes one system clock domain on both sides
`timescale 1ns/100ps
`default_nettype none
interface link_timing_if;
  logic       run;
  logic [1:0] rate;
  logic       resync;
  logic       sync_en;
  logic       clk_level;
  logic       sync_level;
  logic       rise;
  logic       fall;
  modport gen (input run, input rate, input resync, input sync_en,
               output clk_level, output sync_level, output rise, output fall);
  modport eng (output run, output rate, output resync, output sync_en,
               input clk_level, input sync_level, input rise, input fall);
endinterface
`default_nettype wire

//--- design/link_master_gen.sv
// master bit clock and frame sync generator
// assumes a 250 MHz clock; edges are one-cycle enable pulses
`timescale 1ns/100ps
`default_nettype none
module link_master_gen (
  input  wire logic   clk,
  input  wire logic   srst,
  link_timing_if.gen  tif
);
  logic [23:0] acc;
  logic [23:0] next_acc;
  logic [8:0]  cnt;
  logic [8:0]  next_cnt;
  logic        clk_lvl;
  logic        next_clk_lvl;
  logic        sync_lvl;
  logic        next_sync_lvl;
  logic        rise;
  logic        next_rise;
  logic        fall;
  logic        next_fall;
  logic [23:0] inc;
  logic [8:0]  bits;
  logic [24:0] sum;
  logic        tick;

  always_comb
  begin
    unique case (tif.rate)
      link_pkg::RATE_2560:
      begin
        inc  = link_pkg::INC_2560;
        bits = link_pkg::BITS_2560;
      end
      link_pkg::RATE_1536:
      begin
        inc  = link_pkg::INC_1536;
        bits = link_pkg::BITS_1536;
      end
      default:
      begin
        inc  = link_pkg::INC_2048;
        bits = link_pkg::BITS_2048;
      end
    endcase
    sum           = {1'b0, acc} + {1'b0, inc};
    tick          = sum[24] & tif.run;
    next_acc      = sum[23:0];
    next_clk_lvl  = clk_lvl ^ tick;
    next_rise     = tick & ~clk_lvl;
    next_fall     = tick & clk_lvl;
    next_cnt      = cnt;
    next_sync_lvl = sync_lvl;
    if (next_rise)
    begin
      // sync is high from one leading edge to the next
      next_cnt      = (cnt >= bits - 9'h001) ? 9'h000 : cnt + 9'h001;
      next_sync_lvl = (next_cnt == 9'h000) & tif.sync_en;
    end
    if (!tif.run || tif.resync)
    begin
      next_acc      = 24'h000000;
      next_clk_lvl  = 1'b0;
      next_rise     = 1'b0;
      next_fall     = 1'b0;
      next_sync_lvl = 1'b0;
      // restart so that the next leading edge opens a frame
      next_cnt      = bits - 9'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      acc      <= 24'h000000;
      cnt      <= 9'h000;
      clk_lvl  <= 1'b0;
      sync_lvl <= 1'b0;
      rise     <= 1'b0;
      fall     <= 1'b0;
    end
    else
    begin
      acc      <= next_acc;
      cnt      <= next_cnt;
      clk_lvl  <= next_clk_lvl;
      sync_lvl <= next_sync_lvl;
      rise     <= next_rise;
      fall     <= next_fall;
    end
  end

  assign tif.clk_level  = clk_lvl;
  assign tif.sync_level = sync_lvl;
  assign tif.rise       = rise;
  assign tif.fall       = fall;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_sync_on_lead;
    $rose(sync_lvl) |-> rise;
  endproperty
  a_sync_on_lead: assert property (p_sync_on_lead) else $error("sync rose off a leading edge");

  property p_sync_one_period;
    $fell(sync_lvl) && $past(tif.run) && !$past(tif.resync) |-> rise;
  endproperty
  a_sync_one_period: assert property (p_sync_one_period) else $error("sync not one clock period");

  property p_count_bound;
    rise && $stable(tif.rate) |-> cnt < bits;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("frame counter past frame length");

  c_sync_pulse: cover property ($rose(sync_lvl));
endmodule
`default_nettype wire

//--- design/link_port_top.sv
// interchip link frame port with shared mode pins
// assumes pins are asynchronous to clk; status inputs come from same-clock logic
`timescale 1ns/100ps
`default_nettype none
module link_port_top (
  input  wire logic        clk,
  input  wire logic        srst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // configuration and mode pins
  input  wire logic        te_mode_pin,
  input  wire logic        request_or_timing_pin,
  input  wire logic        class_echo_pin,
  // same-clock line side status
  input  wire logic        loop_active,
  input  wire logic        nt_timing_seen,
  input  wire logic        nt_frame_mark,
  input  wire logic        demod_d_bit,
  // mode results
  output logic             fixed_timing,
  output logic             priority_class2,
  output logic             e_channel_bit,
  // link pins
  input  wire logic        frame_sync_in,
  output logic             frame_sync_out,
  output logic             frame_sync_oe,
  input  wire logic        link_bit_clock_in,
  output logic             link_bit_clock_out,
  output logic             link_bit_clock_oe,
  input  wire logic        link_receive_data,
  output logic             link_transmit_data,
  output logic             link_transmit_oe,
  // frame data
  input  wire logic [19:0] tx_word,
  output logic [19:0]      rx_word,
  output logic             rx_valid
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] te_ff;
  logic [1:0] tim_ff;
  logic [1:0] cls_ff;
  logic [2:0] bclk_ff;
  logic [1:0] sync_ff;
  logic [1:0] rxd_ff;
  logic       te_s;
  logic       tim_s;
  logic       cls_s;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      te_ff   <= 2'h0;
      tim_ff  <= 2'h0;
      cls_ff  <= 2'h0;
      bclk_ff <= 3'h0;
      sync_ff <= 2'h0;
      rxd_ff  <= 2'h0;
    end
    else
    begin
      te_ff   <= {te_ff[0], te_mode_pin};
      tim_ff  <= {tim_ff[0], request_or_timing_pin};
      cls_ff  <= {cls_ff[0], class_echo_pin};
      bclk_ff <= {bclk_ff[1:0], link_bit_clock_in};
      sync_ff <= {sync_ff[0], frame_sync_in};
      rxd_ff  <= {rxd_ff[0], link_receive_data};
    end
  end

  assign te_s  = te_ff[1];
  assign tim_s = tim_ff[1];
  assign cls_s = cls_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] nibble_reg_two;
  logic [7:0] byte_reg_seven;
  logic [7:0] byte_reg_thirteen;
  logic [3:0] next_nibble_two;
  logic [7:0] next_byte_seven;
  logic [7:0] next_byte_thirtn;
  logic [7:0] next_rdata;
  logic [7:0] status;
  logic       master_freerun_bit;
  logic       star_mode_bit;
  logic       clk_rate_bit_a;
  logic       clk_rate_bit_b;
  link_pkg::frame_state_e state;

  assign master_freerun_bit = byte_reg_seven[link_pkg::MASTER_FREERUN_POS];
  assign clk_rate_bit_a     = byte_reg_seven[link_pkg::CLK_RATE_A_POS];
  assign clk_rate_bit_b     = byte_reg_thirteen[link_pkg::CLK_RATE_B_POS];
  assign star_mode_bit      = byte_reg_thirteen[link_pkg::STAR_MODE_POS];

  always_comb
  begin
    status = 8'h00;
    status[link_pkg::ST_TE_POS]     = te_s;
    status[link_pkg::ST_LOOP_POS]   = loop_active;
    status[link_pkg::ST_FIXED_POS]  = fixed_timing;
    status[link_pkg::ST_CLASS2_POS] = priority_class2;
    status[link_pkg::ST_MASTER_POS] = link_bit_clock_oe;
    status[link_pkg::ST_XFER_POS]   = (state == link_pkg::ST_XFER);
    next_nibble_two  = nibble_reg_two;
    next_byte_seven  = byte_reg_seven;
    next_byte_thirtn = byte_reg_thirteen;
    if (reg_wr)
    begin
      unique case (reg_addr)
        link_pkg::ADDR_NIBBLE_TWO:  next_nibble_two  = reg_wdata[3:0];
        link_pkg::ADDR_BYTE_SEVEN:  next_byte_seven  = reg_wdata;
        link_pkg::ADDR_BYTE_THIRTN: next_byte_thirtn = reg_wdata;
        default:                    next_nibble_two  = nibble_reg_two;
      endcase
    end
    next_rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        link_pkg::ADDR_NIBBLE_TWO:  next_rdata = {4'h0, nibble_reg_two};
        link_pkg::ADDR_BYTE_SEVEN:  next_rdata = byte_reg_seven;
        link_pkg::ADDR_BYTE_THIRTN: next_rdata = byte_reg_thirteen;
        link_pkg::ADDR_STATUS:      next_rdata = status;
        default:                    next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      nibble_reg_two    <= link_pkg::NIBBLE_TWO_RST;
      byte_reg_seven    <= link_pkg::BYTE_SEVEN_RST;
      byte_reg_thirteen <= link_pkg::BYTE_THIRTN_RST;
      reg_rdata         <= 8'h00;
    end
    else
    begin
      nibble_reg_two    <= next_nibble_two;
      byte_reg_seven    <= next_byte_seven;
      byte_reg_thirteen <= next_byte_thirtn;
      reg_rdata         <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode pins and master/slave selection
  logic next_fixed;
  logic next_class2;
  logic next_echo;
  logic master_drive;
  logic next_master;

  always_comb
  begin
    // demodulator sampling clock: fixed offset from own baud or dpll
    next_fixed  = ~te_s & tim_s;
    next_class2 = te_s & (cls_s | nibble_reg_two[link_pkg::PRIORITY_CLASS_POS]);
    next_echo   = (~te_s & star_mode_bit) ? cls_s : demod_d_bit;
    if (te_s)
      next_master = loop_active | master_freerun_bit;
    else
      next_master = master_freerun_bit;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fixed_timing    <= 1'b0;
      priority_class2 <= 1'b0;
      e_channel_bit   <= 1'b0;
      master_drive    <= 1'b0;
    end
    else
    begin
      fixed_timing    <= next_fixed;
      priority_class2 <= next_class2;
      e_channel_bit   <= next_echo;
      master_drive    <= next_master;
    end
  end

  link_timing_if tif ();

  assign tif.run     = master_drive;
  assign tif.rate    = (clk_rate_bit_a & clk_rate_bit_b & ~te_s) ? link_pkg::RATE_1536 :
                       clk_rate_bit_a ? link_pkg::RATE_2560 : link_pkg::RATE_2048;
  assign tif.resync  = te_s & nt_timing_seen & nt_frame_mark;
  assign tif.sync_en = ~te_s | nt_timing_seen | master_freerun_bit;

  link_master_gen u_gen (
    .clk  (clk),
    .srst (srst),
    .tif  (tif)
  );

  assign link_bit_clock_out = tif.clk_level;
  assign link_bit_clock_oe  = master_drive;
  assign frame_sync_out     = tif.sync_level;
  assign frame_sync_oe      = master_drive;

  ////////////////////////////////////////////////////////////////////////
  // frame engine
  logic        ev_rise;
  logic        ev_fall;
  logic        ev_sync;
  logic        ev_rxd;
  link_pkg::frame_state_e next_state;
  logic [4:0]  rx_cnt;
  logic [4:0]  next_rx_cnt;
  logic [4:0]  tx_cnt;
  logic [4:0]  next_tx_cnt;
  logic [19:0] rx_shift;
  logic [19:0] next_rx_shift;
  logic [19:0] tx_shift;
  logic [19:0] next_tx_shift;
  logic        tx_drive;
  logic        next_tx_drive;
  logic        tx_bit;
  logic        next_tx_bit;
  logic [19:0] next_rx_word;
  logic        next_rx_valid;

  // slave edges from the synchronised pin, accepting any rate
  assign ev_rise = master_drive ? tif.rise : (bclk_ff[1] & ~bclk_ff[2]);
  assign ev_fall = master_drive ? tif.fall : (~bclk_ff[1] & bclk_ff[2]);
  assign ev_sync = master_drive ? tif.sync_level : sync_ff[1];
  assign ev_rxd  = rxd_ff[1];

  always_comb
  begin
    next_state    = state;
    next_rx_cnt   = rx_cnt;
    next_tx_cnt   = tx_cnt;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_tx_drive = tx_drive;
    next_tx_bit   = tx_bit;
    next_rx_word  = rx_word;
    next_rx_valid = 1'b0;
    unique case (state)
      link_pkg::ST_IDLE:
      begin
        next_tx_drive = 1'b0;
      end
      link_pkg::ST_XFER:
      begin
        if (ev_rise)
        begin
          if (tx_cnt < link_pkg::FRAME_BITS_W)
          begin
            next_tx_bit   = tx_shift[19];
            next_tx_shift = {tx_shift[18:0], 1'b1};
            next_tx_drive = 1'b1;
            next_tx_cnt   = tx_cnt + 5'h01;
          end
          else
          begin
            next_tx_drive = 1'b0;
            next_state    = link_pkg::ST_IDLE;
          end
        end
        if (ev_fall && rx_cnt < link_pkg::FRAME_BITS_W)
        begin
          next_rx_shift = {rx_shift[18:0], ev_rxd};
          next_rx_cnt   = rx_cnt + 5'h01;
          if (rx_cnt == link_pkg::FRAME_BITS_W - 5'h01)
          begin
            next_rx_word  = {rx_shift[18:0], ev_rxd};
            next_rx_valid = 1'b1;
          end
        end
      end
    endcase
    // falling edge while sync is high opens the transfer
    if (ev_fall && ev_sync)
    begin
      next_state    = link_pkg::ST_XFER;
      next_rx_cnt   = 5'h00;
      next_tx_cnt   = 5'h00;
      next_tx_drive = 1'b0;
      next_tx_shift = loop_active ? tx_word : link_pkg::IDLE_ONES;
    end
    if (!master_drive && te_s)
      next_state = link_pkg::ST_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state    <= link_pkg::ST_IDLE;
      rx_cnt   <= 5'h00;
      tx_cnt   <= 5'h00;
      rx_shift <= 20'h00000;
      tx_shift <= 20'hFFFFF;
      tx_drive <= 1'b0;
      tx_bit   <= 1'b1;
      rx_word  <= 20'h00000;
      rx_valid <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      rx_cnt   <= next_rx_cnt;
      tx_cnt   <= next_tx_cnt;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      tx_drive <= next_tx_drive;
      tx_bit   <= next_tx_bit;
      rx_word  <= next_rx_word;
      rx_valid <= next_rx_valid;
    end
  end

  // NT star mode lets several ports share the line: drive zeros only
  assign link_transmit_data = tx_bit;
  assign link_transmit_oe   = tx_drive & (te_s | ~star_mode_bit | ~tx_bit) & (state == link_pkg::ST_XFER);

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_nt_fixed;
    !te_s && tim_s |=> fixed_timing;
  endproperty
  a_nt_fixed: assert property (p_nt_fixed) else $error("fixed timing not selected");

  property p_te_adaptive;
    te_s |=> !fixed_timing;
  endproperty
  a_te_adaptive: assert property (p_te_adaptive) else $error("TE left adaptive timing");

  property p_class_or;
    te_s && (cls_s || nibble_reg_two[0]) |=> priority_class2;
  endproperty
  a_class_or: assert property (p_class_or) else $error("class OR not applied");

  property p_class_one;
    te_s && !cls_s && !nibble_reg_two[0] |=> !priority_class2;
  endproperty
  a_class_one: assert property (p_class_one) else $error("class 1 not selected");

  property p_star_echo;
    !te_s && star_mode_bit && $stable(cls_s) |=> e_channel_bit == $past(cls_s);
  endproperty
  a_star_echo: assert property (p_star_echo) else $error("echo pin not sent as E");

  property p_nt_slave;
    !te_s && !master_freerun_bit ##1 !te_s && !master_freerun_bit |-> !frame_sync_oe && !link_bit_clock_oe;
  endproperty
  a_nt_slave: assert property (p_nt_slave) else $error("NT drives link without master bit");

  property p_te_master;
    te_s && loop_active |=> link_bit_clock_oe && frame_sync_oe;
  endproperty
  a_te_master: assert property (p_te_master) else $error("TE not link master");

  property p_tx_window;
    link_transmit_oe |-> state == link_pkg::ST_XFER && tx_cnt >= 5'h01 && tx_cnt <= link_pkg::FRAME_BITS_W;
  endproperty
  a_tx_window: assert property (p_tx_window) else $error("transmit driven outside window");

  property p_rx_count;
    rx_valid |-> $past(rx_cnt) == link_pkg::FRAME_BITS_W - 5'h01 && rx_cnt == link_pkg::FRAME_BITS_W;
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("receive word not 20 bits");

  property p_tx_cap;
    ev_rise && state == link_pkg::ST_XFER && tx_cnt == link_pkg::FRAME_BITS_W |=> !tx_drive;
  endproperty
  a_tx_cap: assert property (p_tx_cap) else $error("more than 20 bits launched");

  property p_te_quiet;
    te_s && !loop_active && !master_freerun_bit |=> !link_bit_clock_oe;
  endproperty
  a_te_quiet: assert property (p_te_quiet) else $error("TE clock out before active loop");

  c_rx_word: cover property (rx_valid);
  c_star_tx: cover property (star_mode_bit && tx_drive && !link_transmit_oe);
  c_resync:  cover property (tif.resync);
endmodule
`default_nettype wire

//--- dv/link_far_end.sv
// far-end link master: bit clock, frame sync and receive data
// assumes the block is an NT slave; 80 ns bit clock, low between frames
`timescale 1ns/100ps
`default_nettype none
module link_far_end (
  output logic      bclk,
  output logic      sync,
  output logic      rxd,
  input  wire logic txd
);
  logic [19:0] got;
  initial
  begin
    bclk = 1'b0;
    sync = 1'b0;
    rxd  = 1'b1;
    got  = 20'h00000;
  end
  ////////////////////////////////////////////////////////////////
  // one frame: sync over fall 0, then 20 bits
  task automatic frame(input logic [19:0] word);
    #1.7;
    sync = 1'b1;
    bclk = 1'b1;
    #40 bclk = 1'b0;
    #40;
    for (int k = 19; k >= 0; k--)
    begin
      sync   = 1'b0;
      bclk   = 1'b1;
      rxd    = word[k];
      #40 bclk = 1'b0;
      got[k] = txd;
      #40;
    end
    bclk = 1'b1;
    rxd  = ~rxd;
    #40 bclk = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the link frame port and mode pins
// assumes the far-end model on the link pins and a 250 MHz clock
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk;
  logic        srst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        te;
  logic        tp;
  logic        cp;
  logic        la;
  logic        dm;
  logic        nts;
  logic        nfm;
  logic        fixed_timing;
  logic        class2;
  logic        e_bit;
  logic        sync_out;
  logic        sync_oe;
  logic        bclk_out;
  logic        bclk_oe;
  logic        txd;
  logic        tx_oe;
  logic [19:0] tx_word;
  logic [19:0] rx_word;
  logic        rx_valid;
  logic [7:0]  rd_val;
  wire         far_bclk;
  wire         far_sync;
  wire         far_rxd;
  wire         sync_pin = sync_oe ? sync_out : far_sync;
  wire         bclk_pin = bclk_oe ? bclk_out : far_bclk;
  wire         tx_pin   = tx_oe ? txd : 1'bz;
  int          fails = 0;
  int          total_checks = 0;
  int          vcnt = 0;

  link_port_top DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .te_mode_pin(te),
    .request_or_timing_pin(tp), .class_echo_pin(cp), .loop_active(la), .nt_timing_seen(nts),
    .nt_frame_mark(nfm), .demod_d_bit(dm), .fixed_timing(fixed_timing), .priority_class2(class2),
    .e_channel_bit(e_bit), .frame_sync_in(sync_pin), .frame_sync_out(sync_out),
    .frame_sync_oe(sync_oe), .link_bit_clock_in(bclk_pin), .link_bit_clock_out(bclk_out),
    .link_bit_clock_oe(bclk_oe), .link_receive_data(far_rxd), .link_transmit_data(txd),
    .link_transmit_oe(tx_oe), .tx_word(tx_word), .rx_word(rx_word), .rx_valid(rx_valid));
  link_far_end u_far (.bclk(far_bclk), .sync(far_sync), .rxd(far_rxd), .txd(tx_pin));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (rx_valid === 1'b1)
      vcnt <= vcnt + 1;
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic pins(input logic t, input logic f, input logic c, input logic d, input logic l);
    @(posedge clk);
    te <= t;
    tp <= f;
    cp <= c;
    dm <= d;
    la <= l;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_modes();
    pins(0, 1, 0, 0, 1);
    check(fixed_timing, 1);
    pins(0, 0, 0, 0, 1);
    check(fixed_timing, 0);
    pins(1, 1, 0, 0, 1);
    check(fixed_timing, 0);
    for (int i = 0; i < 4; i++)
    begin
      wr(link_pkg::ADDR_NIBBLE_TWO, {7'h00, i[1]});
      pins(1, 1, i[0], 0, 1);
      check(class2, i != 0);
    end
    wr(link_pkg::ADDR_NIBBLE_TWO, 8'hF1);
    rd(link_pkg::ADDR_NIBBLE_TWO);
    check(rd_val, 8'h01);
    rd(link_pkg::ADDR_STATUS);
    check(rd_val[link_pkg::ST_TE_POS], 1);
    check(rd_val[link_pkg::ST_MASTER_POS], 1);
    rd(8'h3F);
    check(rd_val, 8'h00);
    wr(link_pkg::ADDR_BYTE_THIRTN, 8'h80);
    pins(0, 0, 1, 0, 1);
    check(e_bit, 1);
    pins(0, 0, 0, 1, 1);
    check(e_bit, 0);
    wr(link_pkg::ADDR_BYTE_THIRTN, 8'h00);
    pins(0, 0, 0, 1, 1);
    check(e_bit, 1);
  endtask
  task automatic t_slave();
    @(posedge clk);
    tx_word <= 20'hA5C3E;
    u_far.frame(20'h3C96B);
    repeat (10) @(posedge clk);
    #1;
    check(u_far.got, 20'hA5C3E);
    check(rx_word, 20'h3C96B);
    check(vcnt, 1);
    check(tx_oe, 0);
    check(sync_oe | bclk_oe, 0);
    // idle loop at frame start: all ones go out
    @(posedge clk);
    la <= 1'b0;
    u_far.frame(20'h5A3C1);
    repeat (10) @(posedge clk);
    #1;
    check(u_far.got, link_pkg::IDLE_ONES);
    check(rx_word, 20'h5A3C1);
    check(vcnt, 2);
  endtask
  task automatic t_master(input logic [7:0] c7, input logic [7:0] c13, input int eb, input int ew);
    int   p;
    int   w;
    int   b;
    logic prev;
    logic ps;
    wr(link_pkg::ADDR_BYTE_SEVEN, 8'h00);
    wr(link_pkg::ADDR_BYTE_THIRTN, c13);
    wr(link_pkg::ADDR_BYTE_SEVEN, c7);
    rd(link_pkg::ADDR_BYTE_SEVEN);
    check(rd_val, c7);
    repeat (3) @(posedge clk);
    #1;
    check(sync_oe & bclk_oe, 1);
    // first pass finds a sync rise, second measures one frame
    for (int f = 0; f < 2; f++)
    begin
      p    = 0;
      w    = 0;
      b    = 0;
      ps   = 1'b1;
      prev = bclk_out;
      while (!(sync_out === 1'b1 && ps === 1'b0) && p < 40000)
      begin
        ps = sync_out;
        @(posedge clk);
        #1;
        p++;
        w += int'(sync_out === 1'b1);
        b += int'(bclk_out === 1'b1 && prev === 1'b0);
        prev = bclk_out;
      end
    end
    check(p inside {[31249:31251]}, 1);
    check(b, eb);
    check(w inside {[ew-1:ew+1]}, 1);
  endtask
  task automatic t_te();
    int p;
    wr(link_pkg::ADDR_BYTE_SEVEN, 8'h00);
    pins(1, 0, 0, 0, 0);
    check(bclk_oe | sync_oe | tx_oe, 0);
    wr(link_pkg::ADDR_BYTE_SEVEN, 8'h08);
    pins(1, 0, 0, 0, 0);
    check(bclk_oe & sync_oe, 1);
    wr(link_pkg::ADDR_BYTE_SEVEN, 8'h00);
    pins(1, 0, 0, 0, 1);
    check(bclk_oe & sync_oe, 1);
    check(sync_out, 0);
    // frame mark restarts the generator: sync on the next leading edge
    @(posedge clk);
    nts <= 1'b1;
    nfm <= 1'b1;
    @(posedge clk);
    nfm <= 1'b0;
    #1;
    p = 0;
    while (sync_out !== 1'b1 && p < 200)
    begin
      @(posedge clk);
      #1;
      p++;
    end
    check(p inside {[61:63]}, 1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    srst      = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    te        = 1'b0;
    tp        = 1'b0;
    cp        = 1'b0;
    la        = 1'b1;
    dm        = 1'b0;
    nts       = 1'b0;
    nfm       = 1'b0;
    tx_word   = 20'h00000;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check(sync_oe | bclk_oe | tx_oe, 0);
    t_slave();
    t_modes();
    t_master(8'h08, 8'h00, 256, 122);
    t_master(8'h0C, 8'h20, 192, 163);
    t_te();
    conclude();
  end
  initial
  begin
    #400000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
